// >>> hw/fsp_pkg.sv
package fsp_pkg;

  // ----------------------------------------------------------------
  // register map (core special function space)
  // ----------------------------------------------------------------
  localparam logic [11:0] FSP_CTRL_ADDR = 12'hFA6;
  localparam logic [11:0] FSP_UNLOCK_ADDR = 12'hFA7;
  localparam logic [11:0] FSP_LATCH_ADDR = 12'hFF5;
  localparam logic [11:0] FSP_PTRL_ADDR = 12'hFF6;
  localparam logic [11:0] FSP_PTRH_ADDR = 12'hFF7;
  localparam logic [11:0] FSP_PTRU_ADDR = 12'hFF8;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int FSP_PAIR_BIT = 5;
  localparam int FSP_ERASE_BIT = 4;
  localparam int FSP_FAULT_BIT = 3;
  localparam int FSP_EN_BIT = 2;
  localparam int FSP_START_BIT = 1;
  localparam logic [7:0] FSP_CTRL_MASK = 8'h3E;
  localparam logic [7:0] FSP_CTRL_RST = 8'h08;
  localparam logic [7:0] FSP_LATCH_RST = 8'h00;
  localparam logic [21:0] FSP_PTR_RST = 22'h000000;

  // ----------------------------------------------------------------
  // unlock keys, sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] FSP_KEY_FIRST = 8'h55;
  localparam logic [7:0] FSP_KEY_SECOND = 8'hAA;
  localparam int FSP_PTR_W = 22;
  localparam int FSP_LOW_W = 21;
  localparam int FSP_HOLD_N = 64;
  localparam int FSP_HOLD_IW = 6;
  localparam logic [15:0] FSP_NOP_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FSP_CLK_NS = 10;
  localparam int FSP_PROG_TIME_NS = 20000;
  localparam int FSP_ERASE_TIME_NS = 30000;
  localparam int FSP_TMR_W = 12;
  localparam logic [11:0] FSP_PROG_CYCLES =
    12'((FSP_PROG_TIME_NS + FSP_CLK_NS - 1) / FSP_CLK_NS);
  localparam logic [11:0] FSP_ERASE_CYCLES =
    12'((FSP_ERASE_TIME_NS + FSP_CLK_NS - 1) / FSP_CLK_NS);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTR_KEEP = 2'b00,
    PTR_POST_INC = 2'b01,
    PTR_POST_DEC = 2'b10,
    PTR_PRE_INC = 2'b11
  } fsp_ptr_mode_t;

  typedef enum logic [1:0] {
    FOP_NONE = 2'b00,
    FOP_ERASE = 2'b01,
    FOP_BLOCK = 2'b10,
    FOP_WORD = 2'b11
  } fsp_flash_op_t;

  typedef struct packed {
    logic valid;
    logic store;
    fsp_ptr_mode_t mode;
  } fsp_tbl_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } fsp_sfr_req_t;

endpackage

// >>> hw/fsp_hold_regs.sv
`timescale 1ns/1ns
module fsp_hold_regs
  import fsp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic [5:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [5:0] rd_idx_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] hold_mem [FSP_HOLD_N];

  // ----------------------------------------------------------------
  // storage, kept across programming cycles
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      hold_mem[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= hold_mem[rd_idx_i];
    end
  end

endmodule

// >>> hw/fsp_ctrl.sv
// What this block does
// - each table fetch moves one byte; address bit 0 picks word half
// - programming covers 64 bytes or one 2-byte word only
// - erase from running code covers one 1024-byte block, no bulk erase
// - fetch stalls during write or erase started from idle; internal timer ends it
// - a fetched word decoding as invalid executes as no-operation
// - every byte moves through the single 8-bit table byte latch
// - table store fills holding registers only, flash untouched
// - table accesses are byte addressed with no alignment required
// - unlock port stores nothing and always reads zero
// - control bit 5 set programs 2 bytes, clear programs 64
// - control bit 4 selects erase, cleared by hardware at its end
// - control bit 2 clear at power-up inhibits every write cycle
// - start bit 1 set-only by software, cleared by hardware at end
// - fault bit 3 set on start, cleared on clean completion
// - pointer is 22 bits from upper, high and low byte registers
// - pointer modes keep, post-inc, post-dec, pre-inc on low 21 bits
// - table fetch uses all 22 pointer bits
// - table store picks holding register from low pointer bits
// - timed write takes target block from top 16 pointer bits, top 21 for a word
// - erase takes block from top 12 pointer bits, rest ignored
// - control bits 7, 6 and 0 read as zero
// - start accepted only after 55h then 0AAh to unlock port
// - holding registers keep contents after programming
`timescale 1ns/1ns
module fsp_ctrl
  import fsp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire fsp_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire fsp_tbl_req_t tbl_req_i,
  output logic tbl_done_o,
  output logic fetch_stall_o,
  input wire logic [15:0] fetch_word_i,
  input wire logic fetch_illegal_i,
  output logic [15:0] fetch_insn_o,
  output logic flash_rd_o,
  output logic [21:0] flash_addr_o,
  input wire logic [15:0] flash_rdata_i,
  output fsp_flash_op_t flash_op_o,
  input wire logic [5:0] hold_rd_idx_i,
  output logic [7:0] hold_rd_data_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD_ISSUE = 2'b01,
    ST_RD_CAP = 2'b10,
    ST_BUSY = 2'b11
  } fsp_state_t;

  typedef enum logic [1:0] {
    UL_NONE = 2'b00,
    UL_FIRST = 2'b01,
    UL_ARMED = 2'b10
  } fsp_unlock_t;

  // ----------------------------------------------------------------
  // pointer arithmetic
  // ----------------------------------------------------------------
  function automatic logic [21:0] fsp_step(input logic [21:0] p,
                                           input logic down);
    logic [20:0] low;
    low = down ? p[20:0] - 21'h000001 : p[20:0] + 21'h000001;
    return {p[21], low};
  endfunction

  function automatic logic [21:0] fsp_access(input logic [21:0] p,
                                             input fsp_ptr_mode_t m);
    return (m == PTR_PRE_INC) ? fsp_step(p, 1'b0) : p;
  endfunction

  function automatic logic [21:0] fsp_after(input logic [21:0] p,
                                            input fsp_ptr_mode_t m);
    logic [21:0] r;
    r = p;
    unique case (m)
      PTR_KEEP: r = p;
      PTR_POST_INC: r = fsp_step(p, 1'b0);
      PTR_POST_DEC: r = fsp_step(p, 1'b1);
      PTR_PRE_INC: r = fsp_step(p, 1'b0);
    endcase
    return r;
  endfunction

  fsp_state_t state_r;
  fsp_unlock_t unlock_r;
  logic [7:0] ctrl_r;
  logic [7:0] latch_r;
  logic [21:0] ptr_r;
  logic [11:0] timer_r;
  logic ctrl_wr;
  logic unlock_wr;
  logic start_req;
  logic start_ok;
  logic op_done;
  logic tbl_take;
  logic store_take;
  logic fetch_take;
  logic [21:0] tbl_addr;
  fsp_flash_op_t start_op;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign ctrl_wr = sfr_req_i.wr && (sfr_req_i.addr == FSP_CTRL_ADDR)
                   && (state_r != ST_BUSY);
  assign unlock_wr = sfr_req_i.wr && (sfr_req_i.addr == FSP_UNLOCK_ADDR)
                     && (state_r != ST_BUSY);
  assign start_req = ctrl_wr && sfr_req_i.wdata[FSP_START_BIT];
  assign start_ok = start_req && sfr_req_i.wdata[FSP_EN_BIT]
                    && (unlock_r == UL_ARMED);
  assign op_done = (state_r == ST_BUSY) && (timer_r == 12'h001);
  assign tbl_take = tbl_req_i.valid && (state_r == ST_IDLE) && !start_ok;
  assign store_take = tbl_take && tbl_req_i.store;
  assign fetch_take = tbl_take && !tbl_req_i.store;
  assign tbl_addr = fsp_access(ptr_r, tbl_req_i.mode);

  always_comb begin
    if (sfr_req_i.wdata[FSP_ERASE_BIT]) begin
      start_op = FOP_ERASE;
    end else if (sfr_req_i.wdata[FSP_PAIR_BIT]) begin
      start_op = FOP_WORD;
    end else begin
      start_op = FOP_BLOCK;
    end
  end

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------
  // two-key sequence
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      unlock_r <= UL_NONE;
    end else if (ctrl_wr) begin
      unlock_r <= UL_NONE;
    end else if (unlock_wr) begin
      if (sfr_req_i.wdata == FSP_KEY_FIRST) begin
        unlock_r <= UL_FIRST;
      end else if (unlock_r == UL_FIRST &&
                   sfr_req_i.wdata == FSP_KEY_SECOND) begin
        unlock_r <= UL_ARMED;
      end else begin
        unlock_r <= UL_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= FSP_CTRL_RST;
    end else if (op_done) begin
      ctrl_r[FSP_START_BIT] <= 1'b0;
      ctrl_r[FSP_FAULT_BIT] <= 1'b0;
      if (flash_op_o == FOP_ERASE) begin
        ctrl_r[FSP_ERASE_BIT] <= 1'b0;
      end
    end else if (ctrl_wr) begin
      ctrl_r[FSP_PAIR_BIT] <= sfr_req_i.wdata[FSP_PAIR_BIT];
      ctrl_r[FSP_ERASE_BIT] <= sfr_req_i.wdata[FSP_ERASE_BIT];
      ctrl_r[FSP_EN_BIT] <= sfr_req_i.wdata[FSP_EN_BIT];
      ctrl_r[FSP_FAULT_BIT] <= sfr_req_i.wdata[FSP_FAULT_BIT];
      if (start_req) begin
        ctrl_r[FSP_FAULT_BIT] <= 1'b1;
      end
      if (start_ok) begin
        ctrl_r[FSP_START_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // table pointer and byte latch
  // ----------------------------------------------------------------
  // pointer bytes
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_r <= FSP_PTR_RST;
    end else if (tbl_take) begin
      ptr_r <= fsp_after(ptr_r, tbl_req_i.mode);
    end else if (sfr_req_i.wr && state_r != ST_BUSY) begin
      unique case (sfr_req_i.addr)
        FSP_PTRL_ADDR: ptr_r[7:0] <= sfr_req_i.wdata;
        FSP_PTRH_ADDR: ptr_r[15:8] <= sfr_req_i.wdata;
        FSP_PTRU_ADDR: ptr_r[21:16] <= sfr_req_i.wdata[5:0];
        default: ptr_r <= ptr_r;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_r <= FSP_LATCH_RST;
    end else if (state_r == ST_RD_CAP) begin
      latch_r <= flash_addr_o[0] ? flash_rdata_i[15:8]
                                 : flash_rdata_i[7:0];
    end else if (sfr_req_i.wr && sfr_req_i.addr == FSP_LATCH_ADDR
                 && state_r != ST_BUSY) begin
      latch_r <= sfr_req_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // holding registers
  // ----------------------------------------------------------------
  // store to holding only
  fsp_hold_regs u_hold (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .wr_en_i(store_take),
    .wr_idx_i(tbl_addr[5:0]),
    .wr_data_i(latch_r),
    .rd_idx_i(hold_rd_idx_i),
    .rd_data_o(hold_rd_data_o)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_ok) begin
            state_r <= ST_BUSY;
          end else if (fetch_take) begin
            state_r <= ST_RD_ISSUE;
          end
        end
        ST_RD_ISSUE: state_r <= ST_RD_CAP;
        ST_RD_CAP: state_r <= ST_IDLE;
        ST_BUSY: begin
          if (op_done) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_r <= 12'h000;
    end else if (start_ok) begin
      timer_r <= (start_op == FOP_ERASE) ? FSP_ERASE_CYCLES
                                         : FSP_PROG_CYCLES;
    end else if (state_r == ST_BUSY) begin
      timer_r <= timer_r - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // array port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_op_o <= FOP_NONE;
      flash_addr_o <= FSP_PTR_RST;
    end else if (start_ok) begin
      flash_op_o <= start_op;
      unique case (start_op)
        FOP_ERASE: flash_addr_o <= {ptr_r[21:10], 10'h000};
        FOP_WORD: flash_addr_o <= {ptr_r[21:1], 1'b0};
        FOP_BLOCK: flash_addr_o <= {ptr_r[21:6], 6'h00};
        FOP_NONE: flash_addr_o <= ptr_r;
      endcase
    end else if (op_done) begin
      flash_op_o <= FOP_NONE;
    end else if (fetch_take) begin
      flash_addr_o <= tbl_addr;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_rd_o <= 1'b0;
      tbl_done_o <= 1'b0;
    end else begin
      flash_rd_o <= fetch_take;
      tbl_done_o <= store_take || (state_r == ST_RD_CAP);
    end
  end

  // ----------------------------------------------------------------
  // instruction fetch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_stall_o <= 1'b0;
      fetch_insn_o <= FSP_NOP_WORD;
    end else begin
      fetch_stall_o <= start_ok || (state_r == ST_BUSY && !op_done);
      fetch_insn_o <= fetch_illegal_i ? FSP_NOP_WORD : fetch_word_i;
    end
  end

  // ----------------------------------------------------------------
  // register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_req_i.rd) begin
      unique case (sfr_req_i.addr)
        FSP_CTRL_ADDR: sfr_rdata_o <= ctrl_r & FSP_CTRL_MASK;
        FSP_UNLOCK_ADDR: sfr_rdata_o <= 8'h00;
        FSP_LATCH_ADDR: sfr_rdata_o <= latch_r;
        FSP_PTRL_ADDR: sfr_rdata_o <= ptr_r[7:0];
        FSP_PTRH_ADDR: sfr_rdata_o <= ptr_r[15:8];
        FSP_PTRU_ADDR: sfr_rdata_o <= {2'b00, ptr_r[21:16]};
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fetch_done;
    @(posedge core_clk_i) disable iff (!resetn_i)
    fetch_take |-> ##3 tbl_done_o;
  endproperty
  a_fetch_done: assert property (p_fetch_done)
    else $error("table fetch did not finish in three cycles");

  property p_stall_op;
    @(posedge core_clk_i) disable iff (!resetn_i)
    start_ok |=> fetch_stall_o && flash_op_o != FOP_NONE;
  endproperty
  a_stall_op: assert property (p_stall_op)
    else $error("accepted start did not stall fetch");

  property p_inhibit;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (start_req && !sfr_req_i.wdata[FSP_EN_BIT] && state_r == ST_IDLE)
      |=> flash_op_o == FOP_NONE && ctrl_r[FSP_FAULT_BIT];
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("start ran with program enable clear");

  property p_unlock_gate;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (start_req && unlock_r != UL_ARMED && state_r == ST_IDLE)
      |=> !ctrl_r[FSP_START_BIT] && flash_op_o == FOP_NONE;
  endproperty
  a_unlock_gate: assert property (p_unlock_gate)
    else $error("start accepted without unlock");

  property p_ctrl_zero;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (sfr_req_i.rd && sfr_req_i.addr == FSP_CTRL_ADDR)
      |=> sfr_rdata_o[7:6] == 2'b00 && !sfr_rdata_o[0];
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("unimplemented control bit read as one");

  property p_unlock_read;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (sfr_req_i.rd && sfr_req_i.addr == FSP_UNLOCK_ADDR)
      |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unlock_read: assert property (p_unlock_read)
    else $error("unlock port read nonzero");

  property p_erase_clear;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (op_done && flash_op_o == FOP_ERASE)
      |=> !ctrl_r[FSP_ERASE_BIT] && !ctrl_r[FSP_START_BIT]
          && !ctrl_r[FSP_FAULT_BIT] && !fetch_stall_o;
  endproperty
  a_erase_clear: assert property (p_erase_clear)
    else $error("erase end left flags set");

  property p_fault_set;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (start_req && state_r == ST_IDLE) |=> ctrl_r[FSP_FAULT_BIT];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault flag not set on start");

  property p_ptr_top;
    @(posedge core_clk_i) disable iff (!resetn_i)
    tbl_take |=> ptr_r[21] == $past(ptr_r[21]);
  endproperty
  a_ptr_top: assert property (p_ptr_top)
    else $error("pointer update touched top bit");

  property p_word_sel;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (start_ok && sfr_req_i.wdata[FSP_PAIR_BIT]
     && !sfr_req_i.wdata[FSP_ERASE_BIT]) |=> flash_op_o == FOP_WORD;
  endproperty
  a_word_sel: assert property (p_word_sel)
    else $error("pair select did not give word program");

  property p_op_holds;
    @(posedge core_clk_i) disable iff (!resetn_i)
    $rose(fetch_stall_o) |-> fetch_stall_o [*8];
  endproperty
  a_op_holds: assert property (p_op_holds)
    else $error("operation ended early");

  c_block: cover property (@(posedge core_clk_i)
    start_ok && start_op == FOP_BLOCK);
  c_word: cover property (@(posedge core_clk_i)
    start_ok && start_op == FOP_WORD);
  c_erase_end: cover property (@(posedge core_clk_i)
    op_done && flash_op_o == FOP_ERASE);
  c_fetch: cover property (@(posedge core_clk_i)
    fetch_take && tbl_req_i.mode == PTR_PRE_INC);

endmodule

// >>> bench/fsp_flash_model.sv
`timescale 1ns/1ns
module fsp_flash_model (
  input wire logic core_clk_i,
  input wire logic rd_i,
  input wire logic [21:0] addr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] q_r = 16'h0F0F;

  // ----------------------------------------
  // array contents and read port
  // ----------------------------------------
  function automatic logic [15:0] word_at(input logic [21:0] a);
    return {a[8:1] ^ 8'h5A, a[8:1] ^ {a[21], 7'h00}};
  endfunction

  // word valid the cycle after a read, else a toggling pattern
  always_ff @(posedge core_clk_i) begin
    q_r <= rd_i ? word_at(addr_i) : ~q_r;
  end
  assign rdata_o = q_r;
endmodule

// >>> bench/fsp_ctrl_tb_top.sv
`timescale 1ns/1ns
module fsp_ctrl_tb_top;
  import fsp_pkg::*;
  logic core_clk_i, resetn_i, done, stall, frd, fill;
  fsp_sfr_req_t sreq;
  fsp_tbl_req_t treq;
  fsp_flash_op_t fop;
  logic [7:0] rdat, hdat, v;
  logic [15:0] fword, finsn, frdata, w;
  logic [21:0] faddr, p, np, a, q;
  logic [5:0] hidx;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  fsp_ptr_mode_t m;
  logic [21:0] pt [5] = '{22'h200011, 22'h000010, 22'h3FFFFF,
                          22'h200000, 22'h12345A};
  logic [1:0] mt [5] = '{2'd0, 2'd1, 2'd3, 2'd2, 2'd1};
  fsp_flash_op_t ot [3] = '{FOP_WORD, FOP_BLOCK, FOP_ERASE};
  logic [7:0] cv [3] = '{8'h26, 8'h06, 8'h16};
  logic [7:0] av [3] = '{8'h24, 8'h04, 8'h04};
  int ct [3] = '{FSP_PROG_CYCLES, FSP_PROG_CYCLES, FSP_ERASE_CYCLES};

  fsp_ctrl u_fsp_ctrl (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .sfr_req_i(sreq), .sfr_rdata_o(rdat), .tbl_req_i(treq),
    .tbl_done_o(done), .fetch_stall_o(stall), .fetch_word_i(fword),
    .fetch_illegal_i(fill), .fetch_insn_o(finsn), .flash_rd_o(frd),
    .flash_addr_o(faddr), .flash_rdata_i(frdata), .flash_op_o(fop),
    .hold_rd_idx_i(hidx), .hold_rd_data_o(hdat));
  fsp_flash_model u_fsp_flash_model (.core_clk_i(core_clk_i),
    .rd_i(frd), .addr_i(faddr), .rdata_o(frdata));

  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string s, logic [21:0] e, logic [21:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tick(int k = 1);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(logic [11:0] ad, logic [7:0] d);
    sreq.addr = ad;
    sreq.wdata = d;
    sreq.wr = 1'b1;
    tick();
    sreq.wr = 1'b0;
    tick();
  endtask
  task automatic rd(logic [11:0] ad, output logic [7:0] d);
    sreq.addr = ad;
    sreq.rd = 1'b1;
    tick();
    sreq.rd = 1'b0;
    tick();
    d = rdat;
  endtask
  task automatic rdc(string s, logic [11:0] ad, logic [7:0] e);
    rd(ad, v);
    chk(s, e, v);
  endtask
  task automatic setp(logic [21:0] x);
    wr(FSP_PTRL_ADDR, x[7:0]);
    wr(FSP_PTRH_ADDR, x[15:8]);
    wr(FSP_PTRU_ADDR, {2'b00, x[21:16]});
  endtask
  task automatic getp(output logic [21:0] x);
    logic [7:0] l, h, u;
    rd(FSP_PTRL_ADDR, l);
    rd(FSP_PTRH_ADDR, h);
    rd(FSP_PTRU_ADDR, u);
    x = {u[5:0], h, l};
  endtask
  task automatic top(logic st, fsp_ptr_mode_t md);
    int k;
    treq = '{1'b1, st, md};
    tick();
    treq.valid = 1'b0;
    for (k = 0; k < 6 && done !== 1'b1; k++) tick();
    chk("done", 1, done);
    tick();
  endtask
  task automatic hchk(logic [5:0] i, logic [7:0] e);
    hidx = i;
    tick(2);
    chk("hold", e, hdat);
  endtask
  task automatic go(logic [7:0] c);
    wr(FSP_UNLOCK_ADDR, FSP_KEY_FIRST);
    wr(FSP_UNLOCK_ADDR, FSP_KEY_SECOND);
    wr(FSP_CTRL_ADDR, c);
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    sreq = '0;
    treq = '0;
    fword = 16'h1234;
    fill = 1'b0;
    hidx = '0;
    resetn_i = 1'b0;
    tick(6);
    resetn_i = 1'b1;
    rdc("ctrl", FSP_CTRL_ADDR, 8'h08);
    rdc("unlock", FSP_UNLOCK_ADDR, 8'h00);
    rdc("latch", FSP_LATCH_ADDR, 8'h00);
    $display("test reset done");
    wr(FSP_CTRL_ADDR, 8'hF6);
    rdc("ctrl_bad", FSP_CTRL_ADDR, 8'h3C);
    chk("op_bad", FOP_NONE, fop);
    wr(FSP_UNLOCK_ADDR, 8'h3C);
    rdc("unlock_rd", FSP_UNLOCK_ADDR, 8'h00);
    wr(FSP_CTRL_ADDR, 8'h00);
    go(8'h02);
    rdc("ctrl_noen", FSP_CTRL_ADDR, 8'h08);
    chk("op_noen", FOP_NONE, fop);
    $display("test control done");
    for (int i = 0; i < 5; i++) begin
      p = pt[i];
      m = fsp_ptr_mode_t'(mt[i]);
      setp(p);
      q = {p[21], p[20:0] + 21'h1};
      a = (m == PTR_PRE_INC) ? q : p;
      np = (m == PTR_KEEP) ? p : (m == PTR_POST_DEC) ?
           {p[21], p[20:0] - 21'h1} : q;
      w = u_fsp_flash_model.word_at(a);
      top(1'b0, m);
      rdc("fetch", FSP_LATCH_ADDR, a[0] ? w[15:8] : w[7:0]);
      getp(q);
      chk("ptr", np, q);
    end
    $display("test fetch done");
    setp(22'h00003F);
    wr(FSP_LATCH_ADDR, 8'hC3);
    top(1'b1, PTR_POST_INC);
    wr(FSP_LATCH_ADDR, 8'h3C);
    top(1'b1, PTR_KEEP);
    getp(q);
    chk("ptr_st", 22'h000040, q);
    hchk(6'd63, 8'hC3);
    hchk(6'd0, 8'h3C);
    chk("op_st", FOP_NONE, fop);
    $display("test store done");
    p = 22'h2ABCDF;
    setp(p);
    for (int i = 0; i < 3; i++) begin
      a = ot[i] == FOP_WORD ? {p[21:1], 1'b0} :
          ot[i] == FOP_BLOCK ? {p[21:6], 6'h00} : {p[21:10], 10'h000};
      go(cv[i]);
      chk("op", ot[i], fop);
      chk("stall", 1, stall);
      chk("addr", a, faddr);
      rdc("ctrl_busy", FSP_CTRL_ADDR, cv[i] | 8'h08);
      wr(FSP_CTRL_ADDR, 8'h00);
      for (n = 0; stall === 1'b1 && n < 4000; n++) tick();
      chk("time", 1, (n + 5 >= ct[i] - 3) && (n + 5 <= ct[i] + 3));
      chk("op_end", FOP_NONE, fop);
      rdc("ctrl_end", FSP_CTRL_ADDR, av[i]);
    end
    hchk(6'd63, 8'hC3);
    $display("test program done");
    go(8'h06);
    treq = '{1'b1, 1'b0, PTR_POST_INC};
    tick();
    treq.valid = 1'b0;
    getp(q);
    chk("ptr_busy", p, q);
    chk("stall_mid", 1, stall);
    resetn_i = 1'b0;
    tick(2);
    resetn_i = 1'b1;
    chk("rst_stall", 0, stall);
    chk("rst_op", FOP_NONE, fop);
    rdc("ctrl_rst", FSP_CTRL_ADDR, 8'h08);
    getp(q);
    chk("ptr_rst", FSP_PTR_RST, q);
    $display("test reset in op done");
    tick();
    chk("insn", 16'h1234, finsn);
    fill = 1'b1;
    tick(2);
    chk("insn_nop", FSP_NOP_WORD, finsn);
    $display("test fetch word done");
    print_verdict();
  end
endmodule
